// >>> src/dstos_pkg.sv
/*
 * Constants and types shared by the stop / torque-off sequencer.
 * Assumes a 100 MHz mclk; all cycle counts derive from that period.
 */
package dstos_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STOP_DELAY_MS = 100;
  localparam int unsigned STARTUP_US    = 1000;
  localparam int unsigned ACKFLT_US     = 10;

  localparam logic [31:0] DELAY_RST =
    32'(STOP_DELAY_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [31:0] STARTUP_CYC_DEF =
    32'(STARTUP_US * 1000 / CLK_PERIOD_NS);
  localparam logic [9:0]  ACKFLT_CYC =
    10'(ACKFLT_US * 1000 / CLK_PERIOD_NS);

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] ADR_CTRL   = 4'h0;
  localparam logic [3:0] ADR_DELAY  = 4'h4;
  localparam logic [3:0] ADR_POSLIM = 4'h8;
  localparam logic [3:0] ADR_STATUS = 4'hc;

  // Control field positions and reset values
  localparam int unsigned CTRL_DRIVE_BIT  = 0;
  localparam int unsigned CTRL_RAMPMON_BIT = 1;
  localparam int unsigned CTRL_STILL_BIT  = 2;
  localparam logic [7:0]  CTRL_RST   = 8'h01;
  localparam logic [15:0] POSLIM_RST = 16'h0100;

  // Status field positions
  localparam int unsigned STAT_ST_LSB   = 0;
  localparam int unsigned STAT_TOFF_BIT = 2;
  localparam int unsigned STAT_RDY_BIT  = 3;
  localparam int unsigned STAT_FLT_BIT  = 4;
  localparam int unsigned STAT_STOP_BIT = 5;
  localparam int unsigned STAT_RSTI_BIT = 6;
  localparam int unsigned STAT_CAUSE_LSB = 8;

  // ==========================================================
  // States, Gray coded along boot -> run -> stop -> off
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN  = 2'b01,
    ST_STOP = 2'b11,
    ST_TOFF = 2'b10
  } dstos_state_t;

  // Reason the power stage was last switched off
  localparam logic [2:0] CAUSE_NONE     = 3'h0;
  localparam logic [2:0] CAUSE_BOTH_LOW = 3'h1;
  localparam logic [2:0] CAUSE_FATAL    = 3'h2;
  localparam logic [2:0] CAUSE_ZERO_DLY = 3'h3;
  localparam logic [2:0] CAUSE_EXPIRED  = 3'h4;
  localparam logic [2:0] CAUSE_NEW_ERR  = 3'h5;
  localparam logic [2:0] CAUSE_POS_ERR  = 3'h6;
  localparam logic [2:0] CAUSE_STILL    = 3'h7;

endpackage : dstos_pkg

// >>> src/dstos_seq.sv
/*
 * Controlled-stop and torque-off sequencer of a servo drive safety card,
 * with a classic Wishbone register slave.
 * Assumes the two stop pins and the acknowledge readback come from
 * outside the mclk domain; error, limit, position error and standstill
 * inputs come from mclk-domain monitor logic.
 */
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps

module dstos_seq
  import dstos_pkg::*;
#(
  parameter logic [31:0] STARTUP_CYC = STARTUP_CYC_DEF
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Safe input pins, active low
  input  wire logic        controlled_stop_request_n,
  input  wire logic        safe_reset_n,
  // Readback of the acknowledge pin
  input  wire logic        torque_off_ack_fb,
  // Monitor inputs from the drive logic
  input  wire logic        fatal_error,
  input  wire logic        internal_error,
  input  wire logic        major_error,
  input  wire logic        limit_exceeded,
  input  wire logic [15:0] position_error,
  input  wire logic        standstill,
  // Safety outputs
  output logic             torque_off_ack,
  output logic             ready,
  output logic             pulse_inhibit,
  output logic             brake_cmd,
  output logic             estop_ramp,
  output logic             limit_ok,
  output logic             others_inhibit
);

  // ==========================================================
  // State record
  typedef struct packed {
    dstos_state_t st;
    logic [31:0]  tmr;
    logic [31:0]  boot_cnt;
    logic [9:0]   flt_cnt;
    logic         ack_fault;
    logic         stop_prev;
    logic         rst_prev;
    logic [1:0]   err_prev;
    logic         estop_src;
    logic [2:0]   cause;
    logic [7:0]   ctrl;
    logic [31:0]  delay;
    logic [15:0]  poslim;
    logic         wb_ack;
    logic [31:0]  wb_dat;
    logic         toff;
    logic         ready;
    logic         pinh;
    logic         brake;
    logic         estop;
    logic         lim_ok;
    logic         others;
  } dstos_regs_t;

  dstos_regs_t r;
  dstos_regs_t n;

  logic [2:0] pins_s;
  logic       stop_s;
  logic       rst_s;
  logic       fb_s;

  logic       fall_stop;
  logic       fall_rst;
  logic       rise_rst;
  logic       both_low;
  logic       start;
  logic       new_err;
  logic       pos_bad;
  logic       still_hit;
  logic       clear_ok;
  logic       bus_req;
  logic       bus_wr;
  logic [31:0] status_w;

  // ==========================================================
  // Pin synchronisers
  // pins synchronised
  dstos_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .mclk     (mclk),
    .srst     (srst),
    .async_in ({torque_off_ack_fb, safe_reset_n,
                controlled_stop_request_n}),
    .sync_out (pins_s)
  );

  assign stop_s = pins_s[0];
  assign rst_s  = pins_s[1];
  assign fb_s   = pins_s[2];

  // ==========================================================
  // Trigger conditions
  // falling and rising edge detect, both-pins-low level
  assign fall_stop = r.stop_prev & ~stop_s;
  assign fall_rst  = r.rst_prev & ~rst_s;
  assign rise_rst  = ~r.rst_prev & rst_s;
  assign both_low  = ~stop_s & ~rst_s;

  assign start = fall_stop | fall_rst | internal_error | limit_exceeded;

  assign new_err = |({internal_error, limit_exceeded} & ~r.err_prev);

  assign pos_bad = r.ctrl[CTRL_RAMPMON_BIT] & (position_error > r.poslim);

  assign still_hit = r.ctrl[CTRL_STILL_BIT] & standstill;

  assign clear_ok = rise_rst & stop_s & ~fatal_error & ~internal_error
                  & ~limit_exceeded;

  // ==========================================================
  // Bus decode helpers
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & r.wb_ack & wb_we_i;

  always_comb begin
    status_w = '0;
    status_w[STAT_ST_LSB +: 2]    = r.st;
    status_w[STAT_TOFF_BIT]       = r.toff;
    status_w[STAT_RDY_BIT]        = r.ready;
    status_w[STAT_FLT_BIT]        = r.ack_fault;
    status_w[STAT_STOP_BIT]       = stop_s;
    status_w[STAT_RSTI_BIT]       = rst_s;
    status_w[STAT_CAUSE_LSB +: 3] = r.cause;
  end

  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ==========================================================
  // Next-state logic
  always_comb begin
    n           = r;
    n.stop_prev = stop_s;
    n.rst_prev  = rst_s;
    n.err_prev  = {internal_error, limit_exceeded};

    // Answer one cycle after the request; drop ack the cycle after
    n.wb_ack = bus_req & ~r.wb_ack;
    n.wb_dat = '0;
    if (n.wb_ack & ~wb_we_i) begin
      if (wb_adr_i == ADR_CTRL) begin
        n.wb_dat = {24'h0, r.ctrl};
      end else if (wb_adr_i == ADR_DELAY) begin
        n.wb_dat = r.delay;
      end else if (wb_adr_i == ADR_POSLIM) begin
        n.wb_dat = {16'h0, r.poslim};
      end else if (wb_adr_i == ADR_STATUS) begin
        n.wb_dat = status_w;
      end else begin
        n.wb_dat = '0;
      end
    end

    // Writes land on the edge where the master sees ack
    if (bus_wr) begin
      if (wb_adr_i == ADR_CTRL) begin
        n.ctrl = 8'(lane_merge({24'h0, r.ctrl}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == ADR_DELAY) begin
        n.delay = lane_merge(r.delay, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_POSLIM) begin
        n.poslim = 16'(lane_merge({16'h0, r.poslim}, wb_dat_i,
                                  wb_sel_i));
      end
    end

    if (fb_s != r.toff) begin
      if (r.flt_cnt == ACKFLT_CYC - 10'h1) begin
        n.ack_fault = 1'b1;
      end else begin
        n.flt_cnt = r.flt_cnt + 10'h1;
      end
    end else begin
      n.flt_cnt = '0;
    end

    case (r.st)
      ST_BOOT: begin
        n.boot_cnt = r.boot_cnt + 32'h1;
        if (r.boot_cnt >= STARTUP_CYC - 32'h1) begin
          // Come up powered only if the controller already allows it
          if (stop_s & rst_s & ~fatal_error) begin
            n.st = ST_RUN;
          end else begin
            n.st    = ST_TOFF;
            n.cause = both_low ? CAUSE_BOTH_LOW : CAUSE_FATAL;
          end
        end
      end
      ST_RUN: begin
        if (both_low) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_BOTH_LOW;
        end else if (fatal_error) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_FATAL;
        end else if (start) begin
          n.estop_src = internal_error | limit_exceeded;
          if (r.delay == 32'h0) begin
            n.st    = ST_TOFF;
            n.cause = CAUSE_ZERO_DLY;
          end else begin
            n.st  = ST_STOP;
            n.tmr = r.delay;
          end
        end
      end
      ST_STOP: begin
        if (both_low) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_BOTH_LOW;
        end else if (fatal_error) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_FATAL;
        end else if (new_err) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_NEW_ERR;
        end else if (pos_bad) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_POS_ERR;
        end else if (still_hit) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_STILL;
        end else if (r.tmr <= 32'h1) begin
          n.st    = ST_TOFF;
          n.cause = CAUSE_EXPIRED;
          n.tmr   = '0;
        end else begin
          n.tmr = r.tmr - 32'h1;
        end
      end
      ST_TOFF: begin
        if (clear_ok) begin
          n.st        = ST_RUN;
          n.estop_src = 1'b0;
          n.tmr       = '0;
        end
      end
      default: begin
        n.st = ST_BOOT;
      end
    endcase

    // Outputs follow the next state so they change with it
    // acknowledge while off
    n.toff   = (n.st == ST_TOFF) | (n.st == ST_BOOT);
    n.pinh   = n.toff;
    n.brake  = (n.st == ST_STOP) & r.ctrl[CTRL_DRIVE_BIT];
    n.estop  = (n.st == ST_STOP) & n.estop_src;
    n.others = (n.st == ST_STOP);
    n.lim_ok = ~limit_exceeded;
    n.ready  = (n.st != ST_BOOT) & ~major_error & ~n.ack_fault;
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      r           <= '0;
      r.st        <= ST_BOOT;
      r.stop_prev <= 1'b1;
      r.rst_prev  <= 1'b1;
      r.ctrl      <= CTRL_RST;
      r.delay     <= DELAY_RST;
      r.poslim    <= POSLIM_RST;
      r.cause     <= CAUSE_NONE;
      // Power stage stays inhibited until start-up completes
      r.toff      <= 1'b1;
      r.pinh      <= 1'b1;
      r.lim_ok    <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign wb_ack_o       = r.wb_ack;
  assign wb_dat_o       = r.wb_dat;
  assign torque_off_ack = r.toff;
  assign ready          = r.ready;
  assign pulse_inhibit  = r.pinh;
  assign brake_cmd      = r.brake;
  assign estop_ramp     = r.estop;
  assign limit_ok       = r.lim_ok;
  assign others_inhibit = r.others;

endmodule : dstos_seq

// >>> src/dstos_sync2.sv
/*
 * Two-stage synchroniser for asynchronous pin levels.
 * Assumes inputs are quasi-static levels; no pulse shorter than
 * one mclk period is guaranteed to pass.
 */
`timescale 1ns/100ps

module dstos_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // Level in and synchronised level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } dstos_sync_t;

  dstos_sync_t r;
  dstos_sync_t n;

  // ==========================================================
  // Stage one feeds only stage two
  always_comb begin
    n    = r;
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  // Inputs idle high, so reset to one avoids a false falling edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;

endmodule : dstos_sync2

// >>> verification/dstos_far_end.sv
/* Far side model: safety controller pins and amplifier readback.
   Assumes the bench sets the commanded pin levels at mclk edges. */
`timescale 1ns/100ps
module dstos_far_end (
  // Commands from the bench
  input  wire logic mclk,
  input  wire logic stop_lvl,
  input  wire logic rst_lvl,
  input  wire logic fb_bad,
  input  wire logic brake_by_card,
  // Card side
  input  wire logic torque_off_ack,
  output logic      controlled_stop_request_n,
  output logic      safe_reset_n,
  output logic      torque_off_ack_fb,
  output logic      ext_brake
);
  // pins idle high; a fall requests the stop
  assign controlled_stop_request_n = stop_lvl;
  assign safe_reset_n              = rst_lvl;
  // controller mode: this side commands braking while it stops
  assign ext_brake = ~brake_by_card & ~(stop_lvl & rst_lvl);
  // Readback lags a cycle; a broken output stage inverts it
  always_ff @(posedge mclk) begin
    torque_off_ack_fb <= torque_off_ack ^ fb_bad;
  end
endmodule : dstos_far_end

// >>> verification/dstos_seq_monitor.sv
/* Port checker for the sequencer.
   Assumes it is bound to every sequencer instance. */
`timescale 1ns/100ps
module dstos_seq_chk (
  // Clock, reset and bus
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins and monitors
  input wire logic        controlled_stop_request_n,
  input wire logic        safe_reset_n,
  input wire logic        fatal_error,
  input wire logic        internal_error,
  input wire logic        limit_exceeded,
  // Outputs
  input wire logic        torque_off_ack,
  input wire logic        ready,
  input wire logic        pulse_inhibit,
  input wire logic        brake_cmd,
  input wire logic        estop_ramp,
  input wire logic        limit_ok,
  input wire logic        others_inhibit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================
  // Bus
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property ($rose(wb_stb_i) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  // ==========================================
  // Safety outputs
  inhibit_path_a: assert property (pulse_inhibit == torque_off_ack)
    else $error("pulse inhibit differs from ack");
  limit_mirror_a: assert property (!srst |=>
    limit_ok == !$past(limit_exceeded))
    else $error("limit feedback wrong");
  both_low_a: assert property (
    (!controlled_stop_request_n && !safe_reset_n) [*4] |=> torque_off_ack)
    else $error("both pins low without torque off");
  fatal_off_a: assert property (fatal_error |=> torque_off_ack)
    else $error("fatal error without torque off");
  error_ramp_a: assert property (
    internal_error && !torque_off_ack && !others_inhibit
    |-> ##[1:3] (estop_ramp || torque_off_ack))
    else $error("internal error did not start ramp");
  stop_excl_a: assert property (
    brake_cmd |-> others_inhibit && !torque_off_ack)
    else $error("brake outside controlled stop");
  off_latched_a: assert property (
    (torque_off_ack && ready && !safe_reset_n) [*3]
    |=> torque_off_ack [*2])
    else $error("torque off cleared too early");
endmodule : dstos_seq_chk
bind dstos_seq dstos_seq_chk chk_i (.*);

// >>> verification/tb_top.sv
/* Self-checking bench for the sequencer.
   Assumes a short boot parameter; far side is the pin model. */
`timescale 1ns/100ps
module tb_top
  import dstos_pkg::*;
;
  logic        mclk = 1'h0, srst = 1'h1;
  logic        wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, torque_off_ack, ready, pulse_inhibit, brake_cmd;
  logic        estop_ramp, limit_ok, others_inhibit, torque_off_ack_fb;
  logic        controlled_stop_request_n, safe_reset_n;
  logic        stop_lvl = 1'h1, rst_lvl = 1'h1, fb_bad = 1'h0;
  logic        brake_by_card = 1'h1, ext_brake;
  logic        fatal_error = 1'h0, internal_error = 1'h0;
  logic        major_error = 1'h0, limit_exceeded = 1'h0, standstill = 1'h0;
  logic [15:0] position_error = 16'h0;
  int          num_errors = 0, total_checks = 0, cycles = 0, n;
  logic [2:0]  ctl [9] = '{3'h1, 3'h1, 3'h1, 3'h3, 3'h5, 3'h0, 3'h1, 3'h1,
                           3'h1};
  logic [7:0]  dly [9] = '{8'h05, 8'hc8, 8'hc8, 8'hc8, 8'hc8, 8'h05, 8'h00,
                           8'h05, 8'hc8};
  logic [2:0]  cau [9] = '{3'h4, 3'h1, 3'h5, 3'h6, 3'h7, 3'h4, 3'h3, 3'h4,
                           3'h2};

  dstos_seq #(.STARTUP_CYC(32'h14)) DUT (.*);
  dstos_far_end far_i (.*);

  always #5 mclk = ~mclk;

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ==========================================
  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    // Only the bench timeout ends a wait for a missing ack
    do begin
      @(posedge mclk);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    chk("wb_ack", 32'h1, wb_ack_o);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb

  task automatic clear_off;
    stop_lvl       <= 1'h1;
    rst_lvl        <= 1'h0;
    internal_error <= 1'h0;
    limit_exceeded <= 1'h0;
    fatal_error    <= 1'h0;
    standstill     <= 1'h0;
    position_error <= 16'h0;
    repeat (5) @(posedge mclk);
    chk("held", 32'h1, torque_off_ack);
    rst_lvl <= 1'h1;
    repeat (8) @(posedge mclk);
    chk("cleared", 32'h0, torque_off_ack);
  endtask : clear_off

  // ==========================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'h0;
    repeat (10) @(posedge mclk);
    chk("boot_ready", 32'h0, ready);
    repeat (30) @(posedge mclk);
    chk("ready", 32'h1, ready);
    chk("ack_out", 32'h0, torque_off_ack);
    wb(1'h0, ADR_CTRL, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    wb(1'h0, ADR_DELAY, 32'h0, rd);
    chk("delay", DELAY_RST, rd);
    wb(1'h0, ADR_POSLIM, 32'h0, rd);
    chk("poslim", 32'h100, rd);
    wb(1'h1, 4'h2, 32'hffffffff, rd);
    wb(1'h0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    wb(1'h1, ADR_STATUS, 32'h0, rd);
    wb(1'h0, ADR_STATUS, 32'h0, rd);
    chk("state_run", 32'h1, rd[1:0]);
    for (int k = 0; k < 9; k++) begin
      wb(1'h1, ADR_CTRL, {29'h0, ctl[k]}, rd);
      wb(1'h1, ADR_DELAY, {24'h0, dly[k]}, rd);
      brake_by_card <= ctl[k][0];
      case (k)
        5: rst_lvl <= 1'h0;
        7: internal_error <= 1'h1;
        8: fatal_error <= 1'h1;
        default: stop_lvl <= 1'h0;
      endcase
      n = 0;
      if (k < 6 || k == 7) begin
        while (others_inhibit !== 1'h1 && n < 20) begin
          @(posedge mclk);
          n++;
        end
        chk("others", 32'h1, others_inhibit);
        chk("brake", ctl[k][0], brake_cmd);
        chk("ext_brake", !ctl[k][0], ext_brake);
        chk("estop", k == 7, estop_ramp);
      end
      case (k)
        1: rst_lvl <= 1'h0;
        2: limit_exceeded <= 1'h1;
        3: position_error <= 16'h0101;
        4: standstill <= 1'h1;
        default: ;
      endcase
      n = 0;
      while (torque_off_ack !== 1'h1 && n < 300) begin
        @(posedge mclk);
        n++;
      end
      if (cau[k] == 3'h4) chk("stop_time", dly[k], n);
      else chk("fast_off", 32'h1, n < 8);
      if (k == 2) chk("limit_ok", 32'h0, limit_ok);
      wb(1'h0, ADR_STATUS, 32'h0, rd);
      chk("cause", cau[k], rd[10:8]);
      chk("state_off", 32'h2, rd[1:0]);
      chk("inhibit", 32'h1, pulse_inhibit);
      clear_off();
    end
    major_error <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("major", 32'h0, ready);
    major_error <= 1'h0;
    repeat (3) @(posedge mclk);
    chk("major_end", 32'h1, ready);
    fb_bad <= 1'h1;
    repeat (int'(ACKFLT_CYC) + 20) @(posedge mclk);
    chk("ack_fault", 32'h0, ready);
    wb(1'h0, ADR_STATUS, 32'h0, rd);
    chk("fault_flag", 32'h1, rd[STAT_FLT_BIT]);
    summarize();
  end
endmodule : tb_top
